// ### chop_detect_config.sv
`timescale 1ns/10ps
// How it works
// - config word 6h, read/write, resets 0600h
// - chop enabled: settle 2^(n+1) modulator periods
// - detect runs when enabled; any/all channels
// - detection after 2^n threshold exceedances
// - window length in conversions from table
// - threshold word 7h holds compare high bits
module chop_detect_config #(
    parameter int unsigned CHOP_DELAY_CAP = chop_detect_pkg::CHOP_DELAY_MAX
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // conversion results
    input wire chop_detect_pkg::conv_t conv_i,
    // measurement status
    output logic chop_phase_o,
    output logic measure_valid_o,
    output logic detect_o,
    output logic irq_o
);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic [15:0] spare, next_spare;
    chop_detect_pkg::cfg_t cfg, next_cfg;
    logic [15:0] thresh, next_thresh;
    logic [2:0] irq_status, next_irq_status;
    logic [2:0] irq_mask, next_irq_mask;
    logic [2:0] irq_clr, events;
    logic [31:0] next_rd;
    logic next_ack, next_irq, req, wr;
    logic [7:0] idx;
    logic [4:0] div_cnt, next_div_cnt;
    logic tick, next_tick;
    logic next_phase, next_meas, chop_start;
    logic settle_busy, settle_done;
    chop_detect_pkg::det_state_t state, next_state;
    logic [7:0] hits, next_hits, target;
    logic [11:0] win, next_win;
    logic next_detect, detect_evt, window_evt, win_end, take, hit;
    logic [chop_detect_pkg::NUM_CH-1:0] exceed;

    // byte-lane merge of a 16-bit register
    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] d,
                                            input logic [3:0] sel);
        logic [15:0] r;
        r = old;
        if (sel[0]) r[7:0] = d[7:0];
        if (sel[1]) r[15:8] = d[15:8];
        return r;
    endfunction : merge16

    // magnitude of a two's complement sample
    function automatic logic [23:0] mag24(input logic [23:0] s);
        return s[23] ? 24'(~s + 24'h000001) : s;
    endfunction : mag24

    // ------------------------------------------------------------
    // modulator tick divider
    // ------------------------------------------------------------
    always_comb begin
        next_tick = (div_cnt == chop_detect_pkg::MOD_DIV_LAST);
        next_div_cnt = next_tick ? 5'h00 : 5'(div_cnt + 5'h01);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div_cnt <= 5'h00;
            tick <= 1'b0;
        end else begin
            div_cnt <= next_div_cnt;
            tick <= next_tick;
        end
    end

    // ------------------------------------------------------------
    // global chop sequencing
    // ------------------------------------------------------------
    // with chop enabled, each measured conversion flips the chop phase and halts measuring
    always_comb begin
        chop_start = cfg.chop_enable && conv_i.valid && measure_valid_o;
        next_phase = chop_phase_o ^ chop_start;
        next_meas = !(chop_start || (settle_busy && !settle_done));
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            chop_phase_o <= 1'b0;
            measure_valid_o <= 1'b1;
        end else begin
            chop_phase_o <= next_phase;
            measure_valid_o <= next_meas;
        end
    end

    chop_settle_timer #(
        .DELAY_CAP(CHOP_DELAY_CAP)
    ) u_settle (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .tick_i(tick),
        .start_i(chop_start),
        .code_i(cfg.chop_settle_delay),
        .busy_o(settle_busy),
        .done_o(settle_done)
    );

    // ------------------------------------------------------------
    // threshold compare per channel
    // ------------------------------------------------------------
    // compares high 16 magnitude bits; the low 8 magnitude bits are not compared
    generate
        for (genvar c = 0; c < chop_detect_pkg::NUM_CH; c++) begin : g_cmp
            logic [23:0] mag;
            assign mag = mag24(conv_i.data[c]);
            assign exceed[c] = mag[23:8] > thresh;
        end
    endgenerate

    // ------------------------------------------------------------
    // current-detect engine
    // ------------------------------------------------------------
    always_comb begin
        take = conv_i.valid && measure_valid_o && cfg.detect_mode_enable;
        hit = cfg.detect_channel_rule ? (&exceed) : (|exceed);
        target = 8'h01 << cfg.detect_hit_count;
        win_end = (win == 12'(chop_detect_pkg::WIN_LEN[cfg.detect_window_length]
                              - 12'h001));
        next_state = state;
        next_hits = hits;
        next_win = win;
        next_detect = detect_o;
        detect_evt = 1'b0;
        window_evt = 1'b0;
        case (state)
            chop_detect_pkg::DET_IDLE: begin
                next_hits = 8'h00;
                next_win = 12'h000;
                next_detect = 1'b0;
                next_state = chop_detect_pkg::DET_RUN;
            end
            chop_detect_pkg::DET_RUN, chop_detect_pkg::DET_HOLD: begin
                if (take) begin
                    next_win = win_end ? 12'h000 : 12'(win + 12'h001);
                    if (win_end) begin
                        window_evt = 1'b1;
                        next_hits = 8'h00;
                        next_detect = 1'b0;
                        next_state = chop_detect_pkg::DET_RUN;
                    end else if (state == chop_detect_pkg::DET_RUN && hit) begin
                        next_hits = 8'(hits + 8'h01);
                    end
                    if (state == chop_detect_pkg::DET_RUN && hit
                        && 8'(hits + 8'h01) == target) begin
                        detect_evt = 1'b1;
                        next_detect = 1'b1;
                        if (!win_end) next_state = chop_detect_pkg::DET_HOLD;
                    end
                end
            end
            default: next_state = chop_detect_pkg::DET_IDLE;
        endcase
        // mode off parks the engine and drops any detection
        if (!cfg.detect_mode_enable) begin
            next_state = chop_detect_pkg::DET_IDLE;
            next_detect = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= chop_detect_pkg::DET_IDLE;
            hits <= 8'h00;
            win <= 12'h000;
            detect_o <= 1'b0;
        end else begin
            state <= next_state;
            hits <= next_hits;
            win <= next_win;
            detect_o <= next_detect;
        end
    end

    // ------------------------------------------------------------
    // wishbone register file and interrupts
    // ------------------------------------------------------------
    // unmapped addresses still ack, read zero and drop writes
    always_comb begin
        req = wb_cyc_i && wb_stb_i && !wb_ack_o;
        wr = req && wb_we_i;
        idx = (wb_adr_i[31:10] == 22'h000000) ? wb_adr_i[9:2] : 8'hFF;
        next_ack = req;
        next_rd = wb_dat_o;
        next_spare = spare;
        next_cfg = cfg;
        next_thresh = thresh;
        next_irq_mask = irq_mask;
        irq_clr = 3'h0;
        if (req && !wb_we_i) begin
            case (idx)
                chop_detect_pkg::IDX_SPARE: next_rd = {16'h0000, spare};
                chop_detect_pkg::IDX_CFG: next_rd = {16'h0000, cfg};
                chop_detect_pkg::IDX_THRESH: next_rd = {16'h0000, thresh};
                chop_detect_pkg::IDX_IRQ_STATUS: next_rd = {29'h00000000, irq_status};
                chop_detect_pkg::IDX_IRQ_MASK: next_rd = {29'h00000000, irq_mask};
                default: next_rd = 32'h00000000;
            endcase
        end
        if (wr) begin
            case (idx)
                chop_detect_pkg::IDX_SPARE: next_spare = merge16(spare, wb_dat_i, wb_sel_i);
                chop_detect_pkg::IDX_CFG: next_cfg = merge16(cfg, wb_dat_i, wb_sel_i);
                chop_detect_pkg::IDX_THRESH: next_thresh = merge16(thresh, wb_dat_i, wb_sel_i);
                chop_detect_pkg::IDX_IRQ_STATUS: irq_clr = wb_sel_i[0] ? wb_dat_i[2:0] : 3'h0;
                chop_detect_pkg::IDX_IRQ_MASK: begin
                    if (wb_sel_i[0]) next_irq_mask = wb_dat_i[2:0];
                end
                default: next_rd = wb_dat_o;
            endcase
        end
        events = 3'h0;
        events[chop_detect_pkg::IRQ_DETECT] = detect_evt;
        events[chop_detect_pkg::IRQ_SETTLED] = settle_done;
        events[chop_detect_pkg::IRQ_WINDOW] = window_evt;
        // a new event outranks a clear in the same cycle
        next_irq_status = (irq_status & ~irq_clr) | events;
        next_irq = |(next_irq_status & next_irq_mask);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            spare <= chop_detect_pkg::SPARE_RST;
            cfg <= chop_detect_pkg::CFG_RST;
            thresh <= chop_detect_pkg::THRESH_RST;
            irq_status <= chop_detect_pkg::IRQ_RST;
            irq_mask <= chop_detect_pkg::IRQ_RST;
            wb_dat_o <= 32'h00000000;
            wb_ack_o <= 1'b0;
            irq_o <= 1'b0;
        end else begin
            spare <= next_spare;
            cfg <= next_cfg;
            thresh <= next_thresh;
            irq_status <= next_irq_status;
            irq_mask <= next_irq_mask;
            wb_dat_o <= next_rd;
            wb_ack_o <= next_ack;
            irq_o <= next_irq;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_ack_single_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o) else $error("ack held two cycles");
    a_ack_after_strobe: assert property (@(posedge clk_i) disable iff (rst_i)
        (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o) else $error("strobe not acked");
    a_cfg_reset_val: assert property (@(posedge clk_i) disable iff (rst_i)
        $past(rst_i) |-> cfg == chop_detect_pkg::CFG_RST)
        else $error("config word reset value wrong");
    a_irq_tracks_status: assert property (@(posedge clk_i) disable iff (rst_i)
        irq_o == |(irq_status & irq_mask)) else $error("irq level mismatch");
    a_chop_halts_meas: assert property (@(posedge clk_i) disable iff (rst_i)
        chop_start |=> !measure_valid_o ##0 settle_busy)
        else $error("measurement not halted after chop");
    a_detect_mode_off: assert property (@(posedge clk_i) disable iff (rst_i)
        !cfg.detect_mode_enable |=> state == chop_detect_pkg::DET_IDLE && !detect_o)
        else $error("detect engine active while disabled");
    a_all_channel_rule: assert property (@(posedge clk_i) disable iff (rst_i)
        (take && state == chop_detect_pkg::DET_RUN && cfg.detect_channel_rule
         && !(&exceed) && !win_end) |=> hits == $past(hits))
        else $error("hit counted without all channels");
    a_hit_target: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(detect_o) |-> 8'($past(hits) + 8'h01) == $past(target))
        else $error("detection before hit target");
    a_window_length: assert property (@(posedge clk_i) disable iff (rst_i)
        window_evt |-> 12'(win + 12'h001)
            == chop_detect_pkg::WIN_LEN[cfg.detect_window_length])
        else $error("window ended at wrong count");

endmodule : chop_detect_config

// ### chop_detect_pkg.sv
package chop_detect_pkg;

    // ------------------------------------------------------------
    // clocking and divider
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ = 200_000_000;
    // modulator tick every MOD_TICK_DIV system clocks (8 MHz)
    localparam int unsigned MOD_TICK_DIV = 25;
    localparam logic [4:0] MOD_DIV_LAST = 5'(MOD_TICK_DIV - 1);
    // longest global-chop settle delay in modulator periods
    localparam int unsigned CHOP_DELAY_MAX = 65536;

    // ------------------------------------------------------------
    // register indices (byte address is index times four)
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_SPARE = 8'h05;
    localparam logic [7:0] IDX_CFG = 8'h06;
    localparam logic [7:0] IDX_THRESH = 8'h07;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'h10;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h11;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [15:0] SPARE_RST = 16'h0000;
    localparam logic [15:0] CFG_RST = 16'h0600;
    localparam logic [15:0] THRESH_RST = 16'h0000;
    localparam logic [2:0] IRQ_RST = 3'h0;

    // ------------------------------------------------------------
    // interrupt bit positions
    // ------------------------------------------------------------
    localparam int unsigned IRQ_DETECT = 0;
    localparam int unsigned IRQ_SETTLED = 1;
    localparam int unsigned IRQ_WINDOW = 2;

    // ------------------------------------------------------------
    // channels and window lengths in conversion periods
    // ------------------------------------------------------------
    localparam int unsigned NUM_CH = 3;
    localparam int unsigned SAMPLE_W = 24;
    localparam logic [11:0] WIN_LEN [8] = '{12'h080, 12'h100, 12'h200, 12'h300,
                                            12'h500, 12'h700, 12'hA00, 12'hE00};

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [2:0] spare_top;
        logic [3:0] chop_settle_delay;
        logic chop_enable;
        logic detect_channel_rule;
        logic [2:0] detect_hit_count;
        logic [2:0] detect_window_length;
        logic detect_mode_enable;
    } cfg_t;

    typedef struct packed {
        logic valid;
        logic [NUM_CH-1:0][SAMPLE_W-1:0] data;
    } conv_t;

    typedef enum logic [1:0] {
        DET_IDLE = 2'b00,
        DET_RUN = 2'b01,
        DET_HOLD = 2'b10
    } det_state_t;

endpackage : chop_detect_pkg

// ### chop_settle_timer.sv
`timescale 1ns/10ps
module chop_settle_timer #(
    parameter int unsigned DELAY_CAP = chop_detect_pkg::CHOP_DELAY_MAX
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // control
    input wire logic tick_i,
    input wire logic start_i,
    input wire logic [3:0] code_i,
    // status
    output logic busy_o,
    output logic done_o
);

    logic [16:0] count;
    logic [16:0] next_count;
    logic [16:0] target;
    logic next_busy;
    logic next_done;

    // ------------------------------------------------------------
    // settle countdown
    // ------------------------------------------------------------
    // code n gives 2^(n+1) periods; the cap only shortens simulation
    always_comb begin
        // five-bit shift amount so code 15 reaches 2^16 instead of wrapping
        target = 17'h00001 << (5'(code_i) + 5'h01);
        if (target > 17'(DELAY_CAP)) begin
            target = 17'(DELAY_CAP);
        end
        next_count = count;
        next_busy = busy_o;
        next_done = 1'b0;
        if (start_i) begin
            next_count = target;
            next_busy = 1'b1;
        end else if (busy_o && tick_i) begin
            next_count = count - 17'h00001;
            if (count == 17'h00001) begin
                next_busy = 1'b0;
                next_done = 1'b1;
            end
        end
    end

    // registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count <= 17'h00000;
            busy_o <= 1'b0;
            done_o <= 1'b0;
        end else begin
            count <= next_count;
            busy_o <= next_busy;
            done_o <= next_done;
        end
    end

    a_settle_done_tick: assert property (@(posedge clk_i) disable iff (rst_i)
        done_o |-> $past(tick_i) && $past(count) == 17'h00001 && !busy_o)
        else $error("settle done without final tick");

endmodule : chop_settle_timer

// ### chop_and_current_detect_config_tb_top.sv
`timescale 1ns/10ps
module chop_and_current_detect_config_tb_top;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic wb_we = 1'b0;
    logic [31:0] wb_adr = 32'h0;
    logic [31:0] wb_wdat = 32'h0;
    logic [3:0] wb_sel = 4'hF;
    logic [31:0] wb_rdat;
    logic wb_ack;
    chop_detect_pkg::conv_t conv = '0;
    logic chop_phase;
    logic meas_valid;
    logic detect;
    logic irq;
    int fail_count = 0;
    int cmp_count = 0;
    logic [31:0] rd;
    int n;
    int c;
    int p;
    typedef struct {logic we; logic [7:0] idx; logic [15:0] wd; logic [31:0] exp;} row_t;
    row_t rows [11];

    // small settle cap keeps the chop runs short
    chop_detect_config #(.CHOP_DELAY_CAP(8)) i_dut (
        .clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
        .wb_dat_i(wb_wdat), .wb_sel_i(wb_sel), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
        .conv_i(conv), .chop_phase_o(chop_phase), .measure_valid_o(meas_valid),
        .detect_o(detect), .irq_o(irq)
    );

    // 200 MHz clock
    initial begin
        forever #2.5 clk_i = ~clk_i;
    end

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // classic single cycle; wait for ack, never assume its latency
    task automatic wb_xfer(input logic we, input logic [7:0] idx, input logic [15:0] wd,
                           output logic [31:0] rdat);
        @(posedge clk_i);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= {22'h0, idx, 2'b00};
        wb_wdat <= {16'h0, wd};
        // no local timeout; if ack never comes, only the watchdog ends this wait
        do begin
            @(posedge clk_i);
        end while (wb_ack !== 1'b1);
        rdat = wb_rdat;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
        // ack stands one cycle only, so it must be low at the next edge
        @(posedge clk_i);
        chk("wb_ack drop", 32'h0, {31'h0, wb_ack});
    endtask : wb_xfer

    task automatic wr(input logic [7:0] idx, input logic [15:0] wd);
        logic [31:0] unused;
        wb_xfer(1'b1, idx, wd, unused);
    endtask : wr

    // one conversion, three samples, valid for a single cycle
    task automatic send_conv(input logic [23:0] s0, input logic [23:0] s1, input logic [23:0] s2);
        @(posedge clk_i);
        conv <= {1'b1, s2, s1, s0};
        @(posedge clk_i);
        conv.valid <= 1'b0;
    endtask : send_conv

    task automatic look(input int cyc);
        repeat (cyc) @(posedge clk_i);
        #1;
    endtask : look

    // watchdog, far beyond the roughly one thousand cycles the tests need
    initial begin
        #300000;
        fail_count++;
        $display("ERROR watchdog expected finish seen timeout");
        end_sim();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        rows = '{'{1'b0, 8'h05, 16'h0000, 32'h0000}, '{1'b0, 8'h06, 16'h0000, 32'h0600},
                 '{1'b0, 8'h07, 16'h0000, 32'h0000}, '{1'b0, 8'h10, 16'h0000, 32'h0000},
                 '{1'b0, 8'h11, 16'h0000, 32'h0000}, '{1'b0, 8'h20, 16'h0000, 32'h0000},
                 '{1'b1, 8'h06, 16'h1FFE, 32'h1FFE}, '{1'b1, 8'h05, 16'h0000, 32'h0000},
                 '{1'b1, 8'h07, 16'hABCD, 32'hABCD}, '{1'b1, 8'h20, 16'h1234, 32'h0000},
                 '{1'b1, 8'h06, 16'h0000, 32'h0000}};
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        // register rows: reset values, write then read back, unmapped place
        foreach (rows[i]) begin
            if (rows[i].we) begin
                wr(rows[i].idx, rows[i].wd);
            end
            wb_xfer(1'b0, rows[i].idx, 16'h0, rd);
            chk($sformatf("reg %h", rows[i].idx), rows[i].exp, rd);
        end
        // chop settle for codes 0, 2 and 15 (bench cap of 8 periods); conversion while settling ignored
        for (int j = 0; j < 3; j++) begin
            c = (j == 2) ? 15 : 2 * j;
            p = ((2 << c) > 8) ? 8 : (2 << c);
            wr(8'h06, 16'h0100 | 16'(c << 9));
            wr(8'h10, 16'h0007);
            send_conv(24'h0, 24'h0, 24'h0);
            #1;
            chk("measure_valid", 32'h0, {31'h0, meas_valid});
            chk("chop_phase", j == 1 ? 32'h0 : 32'h1, {31'h0, chop_phase});
            send_conv(24'h0, 24'h0, 24'h0);
            n = 1;
            while (meas_valid !== 1'b1 && n < 600) begin
                look(1);
                n++;
            end
            chk("settle low", 32'h1, {31'h0, n >= (p - 1) * 25 + 1});
            chk("settle high", 32'h1, {31'h0, n <= p * 25 + 12});
            chk("chop_phase held", j == 1 ? 32'h0 : 32'h1, {31'h0, chop_phase});
            wb_xfer(1'b0, 8'h10, 16'h0, rd);
            chk("settle status", 32'h2, rd & 32'h2);
        end
        // two hits needed, window of 128, interrupt unmasked and cleared
        wr(8'h06, 16'h0000);
        wr(8'h07, 16'h0010);
        wr(8'h10, 16'h0007);
        wr(8'h11, 16'h0001);
        wr(8'h06, 16'h0011);
        send_conv(24'h002000, 24'h000100, 24'h0);
        look(3);
        chk("detect one hit", 32'h0, {31'h0, detect});
        chk("irq one hit", 32'h0, {31'h0, irq});
        send_conv(24'h0, 24'h0, 24'hFFE000);
        look(3);
        chk("detect two hits", 32'h1, {31'h0, detect});
        chk("irq two hits", 32'h1, {31'h0, irq});
        wr(8'h10, 16'h0001);
        look(2);
        chk("irq cleared", 32'h0, {31'h0, irq});
        repeat (125) send_conv(24'h000100, 24'h0, 24'h0);
        wb_xfer(1'b0, 8'h10, 16'h0, rd);
        chk("window early", 32'h0, rd & 32'h4);
        send_conv(24'h0, 24'h0, 24'h0);
        look(2);
        chk("detect window end", 32'h0, {31'h0, detect});
        wb_xfer(1'b0, 8'h10, 16'h0, rd);
        chk("window end", 32'h4, rd & 32'h4);
        // all channels: one channel at the threshold exactly is no hit
        wr(8'h06, 16'h0000);
        wr(8'h06, 16'h0081);
        send_conv(24'h002000, 24'h0, 24'h0);
        send_conv(24'h002000, 24'h001000, 24'h002000);
        look(3);
        chk("detect partial", 32'h0, {31'h0, detect});
        send_conv(24'h002000, 24'hFFE000, 24'h002000);
        look(3);
        chk("detect all", 32'h1, {31'h0, detect});
        wr(8'h06, 16'h0080);
        look(3);
        chk("detect off", 32'h0, {31'h0, detect});
        // reset in mid-run restores the configuration word
        wr(8'h06, 16'h1FFF);
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        #1;
        chk("measure_valid reset", 32'h1, {31'h0, meas_valid});
        wb_xfer(1'b0, 8'h06, 16'h0, rd);
        chk("cfg after reset", 32'h0600, rd);
        end_sim();
    end
endmodule : chop_and_current_detect_config_tb_top
